// [lcs_params.svh]
`ifndef LCS_PARAMS_SVH
`define LCS_PARAMS_SVH

// Group geometry
`define LCS_CELLS 10
`define LCS_REGEN_CELL 5

// Register byte addresses
`define LCS_ADR_MODE 8'h00
`define LCS_ADR_CHAIN 8'h04
`define LCS_ADR_CTRL 8'h08
`define LCS_ADR_CSEL 8'h0C
`define LCS_ADR_LUT_BASE 8'h10
`define LCS_ADR_STATUS 8'h40

// Field positions inside the configuration and status words
`define LCS_FIELD_LO 0
`define LCS_FIELD_HI 16
`define LCS_CHIPRST_EN_BIT 31
`define LCS_STAT_CARRY_BIT 28
`define LCS_STAT_PIN_BIT 29

// Writable bit masks, reserved bits read zero
`define LCS_PAIR_MASK 32'h03FF_03FF
`define LCS_CTRL_MASK 32'h83FF_03FF
`define LCS_LOW_MASK 32'h0000_03FF
`define LCS_LUT_MASK 32'h0000_FFFF

// Reset and power-up values, all-cells and first-cell masks
`define LCS_CFG_RESET 32'h0000_0000
`define LCS_LUT_RESET 16'h0000
`define LCS_POWERUP_MASK 10'h000
`define LCS_ALL_CELLS 10'h3FF
`define LCS_FIRST_CELL 10'h001

`endif

// [lcs_pkg.sv]
`default_nettype none
`include "lcs_params.svh"

package lcs_pkg;
  // One bit per cell of the group
  typedef logic [`LCS_CELLS-1:0] lcs_cells_t;
  // Four-input lookup truth table
  typedef logic [15:0] lcs_lut_t;
  // Bus word
  typedef logic [31:0] lcs_word_t;
  // Index into a lookup table
  typedef logic [3:0] lcs_lut_idx_t;
endpackage

`default_nettype wire

// [lcs_cell_group.sv]
// Contract
// RL1 - Normal mode: four-input lookup, carry or fourth input
// RL2 - Normal mode async load from fourth input
// RL3 - Lookup output cascades to next cell
// RL4 - Arithmetic: two precomputed sums, two carries
// RL5 - Group carry-in picks rail, rail picks sum
// RL6 - Each rail selects its own carry-out
// RL7 - Both rails feed forward to next cell
// RL8 - Chain may start at any cell
// RL9 - Carry selection regenerated at cells five, ten
// RL10 - Final carry delivered to a cell
// RL11 - Chains continue into adjacent group, same row
// RL12 - Sum given registered and unregistered; here the comb copy is also flopped
// RL13 - Count enable, up/down from own inputs
// RL14 - Sync clear, sync load group-wide at edge
// RL15 - Add/subtract select drives first chain carry
// RL16 - Group-wide register controls in every mode
// RL17 - Preset is async load of one
// RL18 - Clear wins over preset/load
// RL19 - Two clears, one preset per group
// RL20 - Chip reset overrides all, else plain pin
// RL21 - Outside holds chip reset low at power-up
// RL22 - Registers power up zero unless configured one; here every register powers up zero, with no power-up-one option
// RL23 - Subtract inverts B, forces first carry one
// RL24 - Clock enable gates the group clock
// RL25 - Counter steps by one or holds
//
// Implementation choices: the Wishbone slave port and the address map.
`default_nettype none
`include "lcs_params.svh"

module lcs_cell_group (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [9:0] operand_a_input_in,
  input wire logic [9:0] operand_b_input_in,
  input wire logic [9:0] third_data_input_in,
  input wire logic [9:0] fourth_data_input_in,
  input wire logic carry_rail_assume_zero_in,
  input wire logic carry_rail_assume_one_in,
  input wire logic group_carry_in,
  input wire logic add_sub_select_in,
  input wire logic group_clock_enable_one_in,
  input wire logic async_clear_one_in,
  input wire logic async_clear_two_in,
  input wire logic async_load_in,
  input wire logic sync_clear_in,
  input wire logic sync_load_in,
  input wire logic chip_wide_reset_low_in,
  output logic [9:0] cell_reg_out,
  output logic [9:0] cell_comb_out,
  output logic carry_rail_assume_zero_out,
  output logic carry_rail_assume_one_out,
  output logic group_carry_out,
  output logic reset_pin_level_out
);

  // Configuration words
  lcs_pkg::lcs_word_t mode_q;
  lcs_pkg::lcs_word_t chain_q;
  lcs_pkg::lcs_word_t ctrl_q;
  lcs_pkg::lcs_word_t csel_q;
  lcs_pkg::lcs_lut_t lut_q [`LCS_CELLS];

  // Cell state and datapath
  lcs_pkg::lcs_cells_t cell_q;
  lcs_pkg::lcs_cells_t cell_d;
  lcs_pkg::lcs_cells_t comb_d;
  lcs_pkg::lcs_cells_t arith_cells;
  lcs_pkg::lcs_cells_t count_cells;
  lcs_pkg::lcs_cells_t start_cells;
  lcs_pkg::lcs_cells_t cascade_cells;
  lcs_pkg::lcs_cells_t clr_two_cells;
  lcs_pkg::lcs_cells_t preset_cells;
  lcs_pkg::lcs_cells_t carry_lut_cells;
  lcs_pkg::lcs_cells_t clear_hit;
  lcs_pkg::lcs_cells_t load_val;
  logic chip_rst_act;
  logic rail0;
  logic rail1;
  logic sel;
  logic prev_lut;
  logic a_v;
  logic b_v;
  logic c_v;
  logic sum0;
  logic sum1;
  logic lut_o;
  logic next_d;
  lcs_pkg::lcs_lut_idx_t idx;
  logic ack_q;
  lcs_pkg::lcs_word_t rdata_q;

  // Byte-lane merge for bus writes
  function automatic lcs_pkg::lcs_word_t lcs_merge(input lcs_pkg::lcs_word_t old_w,
                                                   input lcs_pkg::lcs_word_t new_w,
                                                   input logic [3:0] sel_w,
                                                   input lcs_pkg::lcs_word_t mask_w);
    lcs_pkg::lcs_word_t res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel_w[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res & mask_w;
  endfunction

  // Byte address of one cell's lookup table
  function automatic logic [7:0] lcs_lut_addr(input int k);
    return `LCS_ADR_LUT_BASE + 8'(k * 4);
  endfunction

  // Field extraction
  assign arith_cells = mode_q[`LCS_FIELD_LO +: `LCS_CELLS];
  assign count_cells = mode_q[`LCS_FIELD_HI +: `LCS_CELLS];
  assign start_cells = chain_q[`LCS_FIELD_LO +: `LCS_CELLS];
  assign cascade_cells = chain_q[`LCS_FIELD_HI +: `LCS_CELLS];
  assign clr_two_cells = ctrl_q[`LCS_FIELD_LO +: `LCS_CELLS];
  assign preset_cells = ctrl_q[`LCS_FIELD_HI +: `LCS_CELLS];
  assign carry_lut_cells = csel_q[`LCS_FIELD_LO +: `LCS_CELLS];

  // Pin acts as chip reset only when enabled
  assign chip_rst_act = ctrl_q[`LCS_CHIPRST_EN_BIT] & ~chip_wide_reset_low_in; // [RL20]

  // Bus ack: one cycle after request, dropped next cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_in & wb_stb_in & ~ack_q;
    end
  end

  // Configuration writes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q <= `LCS_CFG_RESET;
      chain_q <= `LCS_CFG_RESET;
      ctrl_q <= `LCS_CFG_RESET;
      csel_q <= `LCS_CFG_RESET;
      for (int k = 0; k < `LCS_CELLS; k++) begin
        lut_q[k] <= `LCS_LUT_RESET;
      end
    end else if (wb_cyc_in && wb_stb_in && wb_we_in && !ack_q) begin
      if (wb_adr_in == `LCS_ADR_MODE) begin
        mode_q <= lcs_merge(mode_q, wb_dat_in, wb_sel_in, `LCS_PAIR_MASK);
      end else if (wb_adr_in == `LCS_ADR_CHAIN) begin
        chain_q <= lcs_merge(chain_q, wb_dat_in, wb_sel_in, `LCS_PAIR_MASK);
      end else if (wb_adr_in == `LCS_ADR_CTRL) begin
        ctrl_q <= lcs_merge(ctrl_q, wb_dat_in, wb_sel_in, `LCS_CTRL_MASK);
      end else if (wb_adr_in == `LCS_ADR_CSEL) begin
        csel_q <= lcs_merge(csel_q, wb_dat_in, wb_sel_in, `LCS_LOW_MASK);
      end else begin
        for (int k = 0; k < `LCS_CELLS; k++) begin
          if (wb_adr_in == lcs_lut_addr(k)) begin
            lut_q[k] <= 16'(lcs_merge({16'h0000, lut_q[k]}, wb_dat_in, wb_sel_in,
                                      `LCS_LUT_MASK));
          end
        end
      end
    end
  end

  // Read data, captured with the ack; unmapped reads zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= `LCS_CFG_RESET;
    end else if (wb_cyc_in && wb_stb_in && !ack_q) begin
      rdata_q <= `LCS_CFG_RESET;
      if (wb_adr_in == `LCS_ADR_MODE) begin
        rdata_q <= mode_q;
      end else if (wb_adr_in == `LCS_ADR_CHAIN) begin
        rdata_q <= chain_q;
      end else if (wb_adr_in == `LCS_ADR_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (wb_adr_in == `LCS_ADR_CSEL) begin
        rdata_q <= csel_q;
      end else if (wb_adr_in == `LCS_ADR_STATUS) begin
        rdata_q[`LCS_FIELD_LO +: `LCS_CELLS] <= cell_q;
        rdata_q[`LCS_FIELD_HI +: `LCS_CELLS] <= cell_comb_out;
        rdata_q[`LCS_STAT_CARRY_BIT] <= group_carry_out;
        rdata_q[`LCS_STAT_PIN_BIT] <= chip_wide_reset_low_in;
      end else begin
        for (int k = 0; k < `LCS_CELLS; k++) begin
          if (wb_adr_in == lcs_lut_addr(k)) begin
            rdata_q <= {16'h0000, lut_q[k]};
          end
        end
      end
    end
  end

  // Carry-select chain, lookup cascade and next register values
  always_comb begin
    rail0 = carry_rail_assume_zero_in;
    rail1 = carry_rail_assume_one_in;
    sel = group_carry_in;
    prev_lut = 1'b0;
    a_v = 1'b0;
    b_v = 1'b0;
    c_v = 1'b0;
    sum0 = 1'b0;
    sum1 = 1'b0;
    lut_o = 1'b0;
    next_d = 1'b0;
    idx = 4'h0;
    cell_d = cell_q;
    comb_d = '0;
    for (int i = 0; i < `LCS_CELLS; i++) begin
      // Actual carry into the middle cell becomes the new selector
      if (i == `LCS_REGEN_CELL) begin
        sel = sel ? rail1 : rail0; // [RL9]
      end
      // Counter cells add their own state to +1 or -1
      a_v = count_cells[i] ? cell_q[i] : operand_a_input_in[i]; // [RL13]
      b_v = count_cells[i] ? ~fourth_data_input_in[i] :
            (operand_b_input_in[i] ^ add_sub_select_in); // [RL23] [RL13]
      // Chain start seeds both rails with the first carry
      if (start_cells[i] && arith_cells[i]) begin // [RL8]
        rail0 = count_cells[i] ? fourth_data_input_in[i] : add_sub_select_in; // [RL15]
        rail1 = rail0;
      end
      c_v = sel ? rail1 : rail0; // [RL5]
      // Two precomputed sums
      sum0 = a_v ^ b_v; // [RL4]
      sum1 = ~(a_v ^ b_v); // [RL4]
      // Lookup input: carry or fourth input; first input may be the cascade
      idx = {carry_lut_cells[i] ? c_v : fourth_data_input_in[i], // [RL1] [RL10]
             third_data_input_in[i],
             operand_b_input_in[i],
             cascade_cells[i] ? prev_lut : operand_a_input_in[i]}; // [RL3]
      lut_o = lut_q[i][idx]; // [RL1]
      prev_lut = lut_o; // [RL3]
      if (arith_cells[i]) begin
        comb_d[i] = c_v ? sum1 : sum0; // [RL5] [RL12]
        next_d = (count_cells[i] && !third_data_input_in[i]) ? cell_q[i] : comb_d[i]; // [RL25]
        // Each rail chooses its own carry-out
        rail0 = rail0 ? (a_v | b_v) : (a_v & b_v); // [RL6] [RL7]
        rail1 = rail1 ? (a_v | b_v) : (a_v & b_v); // [RL6] [RL7]
      end else begin
        comb_d[i] = lut_o;
        next_d = lut_o;
      end
      cell_d[i] = next_d;
    end
  end

  // Per-cell clear choice between the two group clears
  assign clear_hit = (clr_two_cells & {`LCS_CELLS{async_clear_two_in}}) |
                     (~clr_two_cells & {`LCS_CELLS{async_clear_one_in}}); // [RL19]
  // Preset loads one, otherwise the fourth input
  assign load_val = preset_cells | (~preset_cells & fourth_data_input_in); // [RL17] [RL2]

  // Cell registers: chip reset, clear, load, then clocked path
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cell_q <= `LCS_POWERUP_MASK; // [RL22]
    end else if (chip_rst_act) begin
      cell_q <= '0; // [RL20]
    end else begin
      for (int i = 0; i < `LCS_CELLS; i++) begin
        if (clear_hit[i]) begin
          cell_q[i] <= 1'b0; // [RL18]
        end else if (async_load_in) begin
          cell_q[i] <= load_val[i]; // [RL16]
        end else if (group_clock_enable_one_in) begin // [RL24]
          if (sync_clear_in) begin
            cell_q[i] <= 1'b0; // [RL14]
          end else if (sync_load_in) begin
            cell_q[i] <= fourth_data_input_in[i]; // [RL14]
          end else begin
            cell_q[i] <= cell_d[i];
          end
        end
      end
    end
  end

  // Output flops: comb copy, rails, carry into next group of the row
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cell_comb_out <= '0;
      carry_rail_assume_zero_out <= 1'b0;
      carry_rail_assume_one_out <= 1'b0;
      group_carry_out <= 1'b0;
      reset_pin_level_out <= 1'b0;
    end else begin
      cell_comb_out <= comb_d; // [RL12]
      carry_rail_assume_zero_out <= rail0; // [RL11]
      carry_rail_assume_one_out <= rail1; // [RL11]
      group_carry_out <= sel ? rail1 : rail0; // [RL9] [RL11]
      reset_pin_level_out <= chip_wide_reset_low_in; // [RL20]
    end
  end

  assign cell_reg_out = cell_q;
  assign wb_dat_out = rdata_q;
  assign wb_ack_out = ack_q;

  // Helper conditions for the checks below
  logic quiet;
  logic add_cfg;
  logic cnt_cfg;
  assign quiet = !chip_rst_act && !async_clear_one_in && !async_clear_two_in && !async_load_in;
  assign add_cfg = arith_cells == `LCS_ALL_CELLS && start_cells == `LCS_FIRST_CELL &&
                   count_cells == '0;
  assign cnt_cfg = arith_cells == `LCS_ALL_CELLS && count_cells == `LCS_ALL_CELLS &&
                   start_cells == `LCS_FIRST_CELL && fourth_data_input_in == `LCS_ALL_CELLS &&
                   third_data_input_in == `LCS_ALL_CELLS;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_clear_beats_load: assert property ( // [RL18]
    (async_clear_one_in && async_load_in && !chip_rst_act) |=>
      ((cell_q & ~$past(clr_two_cells)) == '0))
    else $error("clear did not win over load");

  a_chip_reset_all: assert property ( // [RL20]
    chip_rst_act |=> cell_q == '0)
    else $error("chip reset did not clear registers");

  a_preset_ones: assert property ( // [RL17]
    (async_load_in && !async_clear_one_in && !async_clear_two_in && !chip_rst_act) |=>
      ((cell_q & $past(preset_cells)) == $past(preset_cells)))
    else $error("preset did not load one");

  a_sync_clear_zero: assert property ( // [RL14]
    (quiet && group_clock_enable_one_in && sync_clear_in) |=> cell_q == '0)
    else $error("sync clear missed");

  a_enable_holds: assert property ( // [RL24]
    (quiet && !group_clock_enable_one_in) |=> $stable(cell_q))
    else $error("register changed with clock disabled");

  a_add_sum_carry: assert property ( // [RL5]
    (add_cfg && !add_sub_select_in) |=>
      (cell_comb_out == $past(10'(operand_a_input_in + operand_b_input_in)) &&
       group_carry_out == $past(1'(({1'b0, operand_a_input_in} +
                                    {1'b0, operand_b_input_in}) >> 10))))
    else $error("adder result wrong");

  // Seeded chain: both rails carry the same real carry out of the group
  a_rails_after_start: assert property ( // [RL6]
    add_cfg |=> (carry_rail_assume_zero_out == carry_rail_assume_one_out &&
                 carry_rail_assume_one_out == group_carry_out))
    else $error("carry rails differ after chain start");

  a_sub_twos_comp: assert property ( // [RL23]
    (add_cfg && add_sub_select_in) |=>
      (cell_comb_out == $past(10'(operand_a_input_in - operand_b_input_in)) &&
       group_carry_out == $past(operand_a_input_in >= operand_b_input_in)))
    else $error("subtract result wrong");

  a_count_step_up: assert property ( // [RL25]
    (cnt_cfg && quiet && group_clock_enable_one_in && !sync_clear_in && !sync_load_in)
      |=> cell_q == $past(10'(cell_q + 10'h001)))
    else $error("counter did not step by one");

  a_ack_one_cycle: assert property (
    ack_q |=> !ack_q)
    else $error("ack longer than one cycle");

endmodule

`default_nettype wire

// [lcs_neighbour_model.sv]
`default_nettype none

// Lower-order group in the same row: hands its chain on as rails plus select
module lcs_neighbour_model (
  input wire logic prev_carry_in,
  output logic rail_zero_out,
  output logic rail_one_out,
  output logic carry_sel_out
);
  // Rails precomputed for both carries, real carry picks one
  assign rail_zero_out = 1'b0;
  assign rail_one_out = 1'b1;
  assign carry_sel_out = prev_carry_in;
endmodule

`default_nettype wire

// [logic_cell_carry_select_bench.sv]
`default_nettype none
`include "lcs_params.svh"

module logic_cell_carry_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [9:0] op_a = 10'h000;
  logic [9:0] op_b = 10'h000;
  logic [9:0] third_in = 10'h000;
  logic [9:0] fourth_in = 10'h000;
  logic prev_carry = 1'b1;
  logic add_sub = 1'b0;
  logic clk_en = 1'b0;
  logic clr_one = 1'b0;
  logic clr_two = 1'b0;
  logic aload = 1'b0;
  logic sclr = 1'b0;
  logic sload = 1'b0;
  logic chip_rst_low = 1'b0; // Held low through power-up
  logic rail_z, rail_o, gsel;
  logic [9:0] cell_reg, cell_comb;
  logic rail0, rail1, gcarry, pin_level;
  int mismatches = 0;
  int n_checks = 0;
  lcs_pkg::lcs_word_t rd;
  logic [10:0] e;
  logic [9:0] ta [4] = '{10'h005, 10'h005, 10'h003, 10'h3FF};
  logic [9:0] tb [4] = '{10'h003, 10'h003, 10'h005, 10'h001};
  logic ts [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [9:0] chains [4] = '{10'h001, 10'h021, 10'h000, 10'h000};

  lcs_neighbour_model nbr (.prev_carry_in(prev_carry), .rail_zero_out(rail_z),
    .rail_one_out(rail_o), .carry_sel_out(gsel));

  lcs_cell_group uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_dat_in(wb_wdat),
    .wb_sel_in(wb_sel), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .operand_a_input_in(op_a), .operand_b_input_in(op_b), .third_data_input_in(third_in),
    .fourth_data_input_in(fourth_in), .carry_rail_assume_zero_in(rail_z),
    .carry_rail_assume_one_in(rail_o), .group_carry_in(gsel), .add_sub_select_in(add_sub),
    .group_clock_enable_one_in(clk_en), .async_clear_one_in(clr_one),
    .async_clear_two_in(clr_two), .async_load_in(aload), .sync_clear_in(sclr),
    .sync_load_in(sload), .chip_wide_reset_low_in(chip_rst_low), .cell_reg_out(cell_reg),
    .cell_comb_out(cell_comb), .carry_rail_assume_zero_out(rail0),
    .carry_rail_assume_one_out(rail1), .group_carry_out(gcarry),
    .reset_pin_level_out(pin_level));

  // 20 MHz clock
  always #25 clk_in = ~clk_in;

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input lcs_pkg::lcs_word_t seen,
                       input lcs_pkg::lcs_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb_access(input logic we, input logic [7:0] adr, input lcs_pkg::lcs_word_t dat,
                           input logic [3:0] sel);
    int n;
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    wb_sel <= sel;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input lcs_pkg::lcs_word_t dat);
    wb_access(1'b1, adr, dat, 4'hF);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr, input lcs_pkg::lcs_word_t exp);
    wb_access(1'b0, adr, 32'h0000_0000, 4'hF);
    check(name, rd, exp);
  endtask

  // Two edges: one to take inputs, one to read the settled result
  task automatic settle();
    repeat (2) @(posedge clk_in);
  endtask

  // Reference ripple adder with chain starts
  function automatic logic [10:0] exp_add(input logic [9:0] a, input logic [9:0] b,
                                          input logic [9:0] chain, input logic sub);
    logic c;
    logic bb;
    logic [9:0] s;
    c = prev_carry;
    for (int i = 0; i < 10; i++) begin
      if (chain[i]) begin
        c = sub;
      end
      bb = b[i] ^ sub;
      s[i] = a[i] ^ bb ^ c;
      c = (a[i] & bb) | (a[i] & c) | (bb & c);
    end
    return {c, s};
  endfunction

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chip_rst_low <= 1'b1;
    check("powerup", cell_reg, `LCS_POWERUP_MASK);
    rd_chk("mode", `LCS_ADR_MODE, `LCS_CFG_RESET);
    wr(8'h80, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h80, 32'h0000_0000);
    wr(`LCS_ADR_MODE, 32'hFFFF_FFFF);
    rd_chk("mode mask", `LCS_ADR_MODE, `LCS_PAIR_MASK);
    wb_access(1'b1, `LCS_ADR_CHAIN, 32'hFFFF_FFFF, 4'b0001);
    rd_chk("chain lane", `LCS_ADR_CHAIN, 32'h0000_00FF);
    // Adders and subtractors, chains from cell 0, cell 5, neighbour with carry-in 0 then 1
    wr(`LCS_ADR_MODE, `LCS_LOW_MASK);
    clk_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      prev_carry <= (c != 2);
      wr(`LCS_ADR_CHAIN, {22'h0, chains[c]});
      for (int k = 0; k < 4; k++) begin
        if (!(chains[c] == 10'h000 && ts[k])) begin
          op_a <= ta[k];
          op_b <= tb[k];
          add_sub <= ts[k];
          settle();
          e = exp_add(ta[k], tb[k], chains[c], ts[k]);
          check("comb", cell_comb, e[9:0]);
          check("reg", cell_reg, e[9:0]);
          check("carry", gcarry, e[10]);
          if (chains[c] != 10'h000 || !prev_carry) begin
            check("rail zero", rail0, e[10]);
          end
          if (chains[c] != 10'h000 || prev_carry) begin
            check("rail one", rail1, e[10]);
          end
        end
      end
    end
    // Register controls
    clk_en <= 1'b0;
    op_a <= 10'h000;
    fourth_in <= 10'h2A5;
    sload <= 1'b1;
    settle();
    check("hold", cell_reg, e[9:0]);
    clk_en <= 1'b1;
    settle();
    check("sload", cell_reg, 32'h0000_02A5);
    sload <= 1'b0;
    sclr <= 1'b1;
    settle();
    check("sclr", cell_reg, 32'h0000_0000);
    sclr <= 1'b0;
    clk_en <= 1'b0;
    aload <= 1'b1;
    settle();
    check("aload", cell_reg, 32'h0000_02A5);
    wr(`LCS_ADR_CTRL, 32'h03FF_0000);
    settle();
    check("preset", cell_reg, `LCS_ALL_CELLS);
    chip_rst_low <= 1'b0;
    settle();
    check("pin io", pin_level, 32'h0000_0000);
    check("pin off", cell_reg, `LCS_ALL_CELLS);
    wr(`LCS_ADR_CTRL, 32'h83FF_0000);
    settle();
    check("chip rst", cell_reg, 32'h0000_0000);
    chip_rst_low <= 1'b1;
    settle();
    check("chip rel", cell_reg, `LCS_ALL_CELLS);
    check("pin high", pin_level, 32'h0000_0001);
    clr_one <= 1'b1;
    settle();
    check("clr wins", cell_reg, 32'h0000_0000);
    wr(`LCS_ADR_CTRL, 32'h03FF_03FF);
    settle();
    check("clr one off", cell_reg, `LCS_ALL_CELLS);
    clr_two <= 1'b1;
    settle();
    check("clr two", cell_reg, 32'h0000_0000);
    clr_one <= 1'b0;
    clr_two <= 1'b0;
    aload <= 1'b0;
    wr(`LCS_ADR_CTRL, `LCS_CFG_RESET);
    // Counter: clear, up three, down two with the turn edge counting up, then hold
    wr(`LCS_ADR_MODE, `LCS_PAIR_MASK);
    wr(`LCS_ADR_CHAIN, {22'h0, `LCS_FIRST_CELL});
    add_sub <= 1'b0;
    clk_en <= 1'b1;
    sclr <= 1'b1;
    third_in <= `LCS_ALL_CELLS;
    fourth_in <= `LCS_ALL_CELLS;
    @(posedge clk_in);
    sclr <= 1'b0;
    repeat (4) @(posedge clk_in);
    check("count up", cell_reg, 32'h0000_0003);
    fourth_in <= 10'h000;
    repeat (3) @(posedge clk_in);
    check("count down", cell_reg, 32'h0000_0002);
    third_in <= 10'h000;
    repeat (3) @(posedge clk_in);
    check("count hold", cell_reg, 32'h0000_0001);
    // Lookup mode, output follows input A, then cell 1 cascades from cell 0
    wr(`LCS_ADR_MODE, `LCS_CFG_RESET);
    wr(`LCS_ADR_CHAIN, `LCS_CFG_RESET);
    for (int k = 0; k < 10; k++) begin
      wr(`LCS_ADR_LUT_BASE + 8'(4 * k), 32'h0000_AAAA);
    end
    op_a <= 10'h001;
    settle();
    check("lookup", cell_comb, 32'h0000_0001);
    wr(`LCS_ADR_CHAIN, 32'h0002_0000);
    settle();
    check("cascade", cell_comb, 32'h0000_0003);
    // Adder in cells 0-8, its final carry feeds cell 9's lookup
    wr(`LCS_ADR_MODE, 32'h0000_01FF);
    wr(`LCS_ADR_CHAIN, {22'h0, `LCS_FIRST_CELL});
    wr(`LCS_ADR_CSEL, 32'h0000_0200);
    wr(`LCS_ADR_LUT_BASE + 8'h24, 32'h0000_FF00);
    op_a <= 10'h1FF;
    op_b <= 10'h001;
    settle();
    check("end carry", cell_comb, 32'h0000_0200);
    rd_chk("status", `LCS_ADR_STATUS, 32'h3200_0200);
    finish_test();
  end
endmodule

`default_nettype wire
